// >>> rtl/crsa_pkg.sv
// package: register map, field layout and timing constants of the rate select block
package crsa_pkg;
  // register indices (byte-free word addresses)
  localparam logic [11:0] ADDR_SPDIF_TX_RATE_CTRL = 12'h5c2;
  localparam logic [11:0] ADDR_BUS_RX_RATES_A     = 12'h5e5;
  localparam logic [11:0] ADDR_BUS_RX_RATES_B     = 12'h5e6;
  localparam logic [11:0] ADDR_BUS_TX_RATES_A     = 12'h5e9;
  localparam logic [11:0] ADDR_BUS_TX_RATES_B     = 12'h5ea;
  localparam logic [11:0] ADDR_BUS_TX_RATES_C     = 12'h5eb;
  localparam logic [11:0] ADDR_EFFECTS_RATE_CTRL  = 12'he00;
  localparam logic [11:0] ADDR_CONV_ENABLE        = 12'hee0;
  localparam logic [11:0] ADDR_CONV_STATUS        = 12'hee1;
  localparam logic [11:0] ADDR_CONV_SYSTEM_RATE   = 12'hee2;
  localparam logic [11:0] ADDR_CONV_ASYNC_RATE    = 12'hee3;
  localparam logic [11:0] ADDR_CONV_EVENTS        = 12'hee4;
  localparam logic [11:0] ADDR_CONV_CAPACITY      = 12'hee5;
  // field positions
  localparam int SPDIF_RATE_LSB = 4;
  localparam int HI_RATE_LSB    = 11;
  localparam int LO_RATE_LSB    = 3;
  // rate codes
  localparam logic [3:0] RATE_SYS_ONE   = 4'h0;
  localparam logic [3:0] RATE_SYS_THREE = 4'h2;
  localparam logic [3:0] RATE_ASYNC_ONE = 4'h8;
  localparam logic [3:0] RATE_ASYNC_TWO = 4'h9;
  // reset values
  localparam logic [3:0] RST_RATE       = 4'h0;
  localparam logic [3:0] RST_ASYNC_RATE = 4'h8;
  // path indices in enable and status registers
  localparam int PATH_A_RIGHT = 0;
  localparam int PATH_A_LEFT  = 1;
  localparam int PATH_B_RIGHT = 2;
  localparam int PATH_B_LEFT  = 3;
  localparam int NUM_PATHS    = 4;
  // timing: lock settle time in ns, cycles at 20 MHz
  localparam int CLK_PERIOD_NS = 50;
  localparam int LOCK_TIME_NS  = 1000;
  localparam int LOCK_CYCLES   = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // default cycle budget per path (arbitrary units)
  localparam logic [7:0] PATH_COST = 8'h04;
  localparam logic [7:0] RST_CAPACITY = 8'h10;
endpackage : crsa_pkg

// >>> rtl/crsa_lock_timer.sv
// module: per-path lock settle timer
`timescale 1ns/1ns
module crsa_lock_timer #(
  parameter int CYCLES = 20
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic ce,
  input  wire logic run,      // path running
  input  wire logic restart,  // clock or rate change
  output logic      locked
);
  localparam int W = $clog2(CYCLES + 1);
  logic [W-1:0] count;  // cycles elapsed since run or restart

  // counter holds at terminal value; restart reopens settle window
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count  <= '0;
      locked <= 1'b0;
    end else if (ce) begin
      if (!run || restart) begin
        count  <= '0;
        locked <= 1'b0;
      end else if (count == W'(CYCLES - 1)) begin
        locked <= 1'b1;
      end else begin
        count <= count + W'(1);
      end
    end
  end
endmodule : crsa_lock_timer

// >>> rtl/crsa_core.sv
// module: rate select registers and cross-domain converter control
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ns
// Behaviour
// - transmitter rate field bits 7:4, system codes
// - four receive rate fields, bits 14:11, 6:3
// - six transmit rate fields, same codes
// - one effects rate field bits 14:11
// - two stereo paths bridge both domains
// - system rate field takes system codes only
// - async rate field takes async codes only
// - first converter system to async, enables
// - second converter async to system, enables
// - enable bits 3,2,1,0, reset zero
// - lock delayed, reported as event source
// - lock routed to general purpose pin
// - capacity checked, failed enable leaves others
// - underclock error on pin and event
// - read-only status shows granted (running) paths
// - first converter right enable at bit 0
// - status shows granted (running) paths bits 3 to 0
// - system rate bits 14:11, reset 0000
// - async rate bits 14:11, reset 1000
module crsa_core #(
  parameter int SAMPLE_W = 24
) (
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic                ce,
  input  wire logic [11:0]         addr,
  input  wire logic [15:0]         wdata,
  input  wire logic                wr,
  input  wire logic                rd,
  output logic      [15:0]         rdata,
  input  wire logic [SAMPLE_W-1:0] sys_in_left,
  input  wire logic [SAMPLE_W-1:0] sys_in_right,
  input  wire logic [SAMPLE_W-1:0] async_in_left,
  input  wire logic [SAMPLE_W-1:0] async_in_right,
  output logic      [SAMPLE_W-1:0] async_out_left,
  output logic      [SAMPLE_W-1:0] async_out_right,
  output logic      [SAMPLE_W-1:0] sys_out_left,
  output logic      [SAMPLE_W-1:0] sys_out_right,
  output logic      [3:0]          spdif_tx_rate_sel,
  output logic      [3:0]          effects_rate_sel,
  output logic      [3:0]          converter_system_rate_sel,
  output logic      [3:0]          converter_async_rate_sel,
  output logic      [3:0]          lock_event,
  output logic      [3:0]          lock_gpio,
  output logic                     underclock_event,
  output logic                     underclock_gpio
);
  localparam int NP = crsa_pkg::NUM_PATHS;

  // rate fields: stored as written, legality judged on write
  logic [3:0] bus_rx_chan_rate_sel [4];  // receive channels 1..4
  logic [3:0] bus_tx_chan_rate_sel [6];  // transmit channels 1..6
  logic [NP-1:0] conv_enable;            // requested enables
  logic [NP-1:0] conv_running;           // enables actually granted
  logic [NP-1:0] lock;                   // per-path lock from timers
  logic [NP-1:0] lock_gpio_sel;          // which locks reach the pin
  logic [7:0]    capacity;               // cycle budget of the clocks
  logic          underclock_flag;        // sticky underclock error
  logic          rate_change;            // converter rate rewritten
  logic [NP-1:0] failed;                 // refused enables, held until cleared

  // legal code for a receive/transmit/effects field
  function automatic logic any_rate_ok(input logic [3:0] c);
    any_rate_ok = (c <= crsa_pkg::RATE_SYS_THREE) ||
                  (c == crsa_pkg::RATE_ASYNC_ONE) || (c == crsa_pkg::RATE_ASYNC_TWO);
  endfunction : any_rate_ok

  // legal code for a system-only field
  function automatic logic sys_rate_ok(input logic [3:0] c);
    sys_rate_ok = (c <= crsa_pkg::RATE_SYS_THREE);
  endfunction : sys_rate_ok

  // legal code for an async-only field
  function automatic logic async_rate_ok(input logic [3:0] c);
    async_rate_ok = (c == crsa_pkg::RATE_ASYNC_ONE) || (c == crsa_pkg::RATE_ASYNC_TWO);
  endfunction : async_rate_ok

  // write decode; reserved codes are ignored so fields never hold them
  wire wr_ce = wr && ce;
  wire [3:0] w_hi = wdata[crsa_pkg::HI_RATE_LSB +: 4];
  wire [3:0] w_lo = wdata[crsa_pkg::LO_RATE_LSB +: 4];
  wire [3:0] w_sp = wdata[crsa_pkg::SPDIF_RATE_LSB +: 4];

  // transmitter and effects fields
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      spdif_tx_rate_sel <= crsa_pkg::RST_RATE;
      effects_rate_sel  <= crsa_pkg::RST_RATE;
    end else if (wr_ce) begin
      if (addr == crsa_pkg::ADDR_SPDIF_TX_RATE_CTRL && sys_rate_ok(w_sp))
        spdif_tx_rate_sel <= w_sp;
      if (addr == crsa_pkg::ADDR_EFFECTS_RATE_CTRL && any_rate_ok(w_hi))
        effects_rate_sel <= w_hi;
    end
  end

  // receive fields, two per register
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_rx
      localparam logic [11:0] RA = (g < 2) ? crsa_pkg::ADDR_BUS_RX_RATES_A
                                           : crsa_pkg::ADDR_BUS_RX_RATES_B;
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          bus_rx_chan_rate_sel[g] <= crsa_pkg::RST_RATE;
        end else if (wr_ce && addr == RA) begin
          if (g % 2 == 0 && any_rate_ok(w_lo))
            bus_rx_chan_rate_sel[g] <= w_lo;
          else if (g % 2 == 1 && any_rate_ok(w_hi))
            bus_rx_chan_rate_sel[g] <= w_hi;
        end
      end
    end
    // transmit fields, two per register
    for (g = 0; g < 6; g++) begin : g_tx
      localparam logic [11:0] TA = (g < 2) ? crsa_pkg::ADDR_BUS_TX_RATES_A :
                                   (g < 4) ? crsa_pkg::ADDR_BUS_TX_RATES_B
                                           : crsa_pkg::ADDR_BUS_TX_RATES_C;
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          bus_tx_chan_rate_sel[g] <= crsa_pkg::RST_RATE;
        end else if (wr_ce && addr == TA) begin
          if (g % 2 == 0 && any_rate_ok(w_lo))
            bus_tx_chan_rate_sel[g] <= w_lo;
          else if (g % 2 == 1 && any_rate_ok(w_hi))
            bus_tx_chan_rate_sel[g] <= w_hi;
        end
      end
    end
  endgenerate

  // converter rate fields; a change restarts lock acquisition
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      converter_system_rate_sel <= crsa_pkg::RST_RATE;
      converter_async_rate_sel  <= crsa_pkg::RST_ASYNC_RATE;
      rate_change               <= 1'b0;
    end else if (ce) begin
      rate_change <= 1'b0;
      if (wr && addr == crsa_pkg::ADDR_CONV_SYSTEM_RATE && sys_rate_ok(w_hi)) begin
        converter_system_rate_sel <= w_hi;
        rate_change               <= 1'b1;
      end
      if (wr && addr == crsa_pkg::ADDR_CONV_ASYNC_RATE && async_rate_ok(w_hi)) begin
        converter_async_rate_sel <= w_hi;
        rate_change              <= 1'b1;
      end
    end
  end

  // enable register, gpio routing, capacity budget
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      conv_enable   <= '0;
      lock_gpio_sel <= '0;
      capacity      <= crsa_pkg::RST_CAPACITY;
    end else if (wr_ce) begin
      if (addr == crsa_pkg::ADDR_CONV_ENABLE)
        conv_enable <= wdata[NP-1:0];
      if (addr == crsa_pkg::ADDR_CONV_EVENTS)
        lock_gpio_sel <= wdata[NP+3:NP];
      if (addr == crsa_pkg::ADDR_CONV_CAPACITY)
        capacity <= wdata[7:0];
    end
  end

  // grant every new enable that fits, in index order, in one cycle; running paths untouched
  logic [7:0] used;        // budget consumed by running paths
  logic [NP-1:0] next_running;
  logic          next_fail;
  always_comb begin
    used         = '0;
    next_running = conv_running & conv_enable;  // disable always honoured
    next_fail    = 1'b0;
    for (int i = 0; i < NP; i++)
      if (next_running[i])
        used = used + crsa_pkg::PATH_COST;
    for (int i = 0; i < NP; i++) begin
      if (conv_enable[i] && !next_running[i] && !conv_running[i] && !failed[i]) begin
        if (used + crsa_pkg::PATH_COST <= capacity) begin
          next_running[i] = 1'b1;
          used            = used + crsa_pkg::PATH_COST;
        end else begin
          next_fail = 1'b1;
        end
      end
    end
  end

  // failed request stays requested but never runs until re-enabled
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      conv_running    <= '0;
      failed          <= '0;
      underclock_flag <= 1'b0;
    end else if (ce) begin
      for (int i = 0; i < NP; i++) begin
        if (!conv_enable[i])
          failed[i] <= 1'b0;
        else if (!conv_running[i] && !next_running[i])
          failed[i] <= 1'b1;
      end
      conv_running <= next_running & ~failed;
      // set wins over clear by a status read
      if (next_fail && (conv_enable & ~conv_running & ~failed) != '0)
        underclock_flag <= 1'b1;
      else if (rd && addr == crsa_pkg::ADDR_CONV_STATUS)
        underclock_flag <= 1'b0;
    end
  end

  // one settle timer per path
  generate
    for (g = 0; g < NP; g++) begin : g_lock
      crsa_lock_timer #(.CYCLES(crsa_pkg::LOCK_CYCLES)) u_timer (
        .clk     (clk),
        .reset   (reset),
        .ce      (ce),
        .run     (conv_running[g]),
        .restart (rate_change),
        .locked  (lock[g])
      );
    end
  endgenerate

  // event and gpio outputs, registered
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lock_event       <= '0;
      lock_gpio        <= '0;
      underclock_event <= 1'b0;
      underclock_gpio  <= 1'b0;
    end else if (ce) begin
      lock_event       <= lock;
      lock_gpio        <= lock & lock_gpio_sel;
      underclock_event <= underclock_flag;
      underclock_gpio  <= underclock_flag;
    end
  end

  // sample paths: zero unless the path's timer reports lock
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      async_out_left  <= '0;
      async_out_right <= '0;
      sys_out_left    <= '0;
      sys_out_right   <= '0;
    end else if (ce) begin
      async_out_left  <= lock[crsa_pkg::PATH_A_LEFT]  ? sys_in_left    : '0;
      async_out_right <= lock[crsa_pkg::PATH_A_RIGHT] ? sys_in_right   : '0;
      sys_out_left    <= lock[crsa_pkg::PATH_B_LEFT]  ? async_in_left  : '0;
      sys_out_right   <= lock[crsa_pkg::PATH_B_RIGHT] ? async_in_right : '0;
    end
  end

  // read port: data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata <= '0;
    end else if (ce) begin
      rdata <= '0;
      if (rd) begin
        unique case (addr)
          crsa_pkg::ADDR_SPDIF_TX_RATE_CTRL: rdata[7:4] <= spdif_tx_rate_sel;
          crsa_pkg::ADDR_BUS_RX_RATES_A:
            rdata <= {1'b0, bus_rx_chan_rate_sel[1], 4'h0, bus_rx_chan_rate_sel[0], 3'h0};
          crsa_pkg::ADDR_BUS_RX_RATES_B:
            rdata <= {1'b0, bus_rx_chan_rate_sel[3], 4'h0, bus_rx_chan_rate_sel[2], 3'h0};
          crsa_pkg::ADDR_BUS_TX_RATES_A:
            rdata <= {1'b0, bus_tx_chan_rate_sel[1], 4'h0, bus_tx_chan_rate_sel[0], 3'h0};
          crsa_pkg::ADDR_BUS_TX_RATES_B:
            rdata <= {1'b0, bus_tx_chan_rate_sel[3], 4'h0, bus_tx_chan_rate_sel[2], 3'h0};
          crsa_pkg::ADDR_BUS_TX_RATES_C:
            rdata <= {1'b0, bus_tx_chan_rate_sel[5], 4'h0, bus_tx_chan_rate_sel[4], 3'h0};
          crsa_pkg::ADDR_EFFECTS_RATE_CTRL: rdata[14:11] <= effects_rate_sel;
          crsa_pkg::ADDR_CONV_ENABLE:       rdata[3:0] <= conv_enable;
          crsa_pkg::ADDR_CONV_STATUS:
            rdata <= {11'h000, underclock_flag, conv_running};
          crsa_pkg::ADDR_CONV_SYSTEM_RATE:  rdata[14:11] <= converter_system_rate_sel;
          crsa_pkg::ADDR_CONV_ASYNC_RATE:   rdata[14:11] <= converter_async_rate_sel;
          crsa_pkg::ADDR_CONV_EVENTS:       rdata <= {8'h00, lock_gpio_sel, lock};
          crsa_pkg::ADDR_CONV_CAPACITY:     rdata[7:0] <= capacity;
          default:                          rdata <= '0;
        endcase
      end
    end
  end

  // checks
  // rate fields never hold a reserved code
  AST_SYS_RATE_LEGAL: assert property (@(posedge clk) disable iff (reset)
    converter_system_rate_sel <= crsa_pkg::RATE_SYS_THREE)
    else $error("system rate holds reserved code");
  AST_ASYNC_RATE_LEGAL: assert property (@(posedge clk) disable iff (reset)
    converter_async_rate_sel[3:1] == 3'h4)
    else $error("async rate holds reserved code");
  AST_RUN_NEEDS_ENABLE: assert property (@(posedge clk) disable iff (reset)
    ce && !conv_enable[0] |=> !conv_running[0])
    else $error("path runs without enable");
  // a refused enable must leave every running path alone
  AST_FAIL_KEEPS_RUNNING: assert property (@(posedge clk) disable iff (reset)
    ce && next_fail && (conv_running & conv_enable) != '0
      |=> (conv_running & $past(conv_running & conv_enable)) == $past(conv_running & conv_enable))
    else $error("failed enable disturbed running path");
  AST_ZERO_WHEN_UNLOCKED: assert property (@(posedge clk) disable iff (reset)
    ce && !lock[crsa_pkg::PATH_A_LEFT] |=> async_out_left == '0)
    else $error("unlocked path passed samples");
  AST_LOCK_DELAYED: assert property (@(posedge clk) disable iff (reset)
    $rose(conv_running[1]) |-> !lock[1])
    else $error("lock immediate after enable");
  // a converter rate write must drop every lock for a fresh settle
  AST_RESTART_UNLOCKS: assert property (@(posedge clk) disable iff (reset)
    ce && rate_change |=> lock == '0)
    else $error("lock kept across rate change");
  AST_UNDER_PIN: assert property (@(posedge clk) disable iff (reset)
    ce && underclock_flag |=> underclock_gpio && underclock_event)
    else $error("underclock not reported");
  // routing mask gates the pin output
  AST_GPIO_GATED: assert property (@(posedge clk) disable iff (reset)
    ce && !lock_gpio_sel[2] |=> !lock_gpio[2])
    else $error("lock on pin without routing");
  // clock enable low freezes registers, timers and read data alike
  AST_CE_FREEZE: assert property (@(posedge clk) disable iff (reset)
    !ce |=> $stable({converter_system_rate_sel, conv_enable, conv_running, lock, rdata}))
    else $error("state moved while clock enable low");
  // covers: lock, refusal, full load, lock loss, frozen write
  COV_LOCK: cover property (@(posedge clk) disable iff (reset) $rose(lock[0]));
  COV_FAIL: cover property (@(posedge clk) disable iff (reset) $rose(underclock_flag));
  COV_ALL: cover property (@(posedge clk) disable iff (reset) &conv_running);
  COV_RELOCK: cover property (@(posedge clk) disable iff (reset) $fell(lock[3]));
  COV_CE_HOLD: cover property (@(posedge clk) disable iff (reset) !ce && wr);
endmodule : crsa_core

// >>> tb/crsa_source_model.sv
// partner model: mixers and sources feeding both converter domains
`timescale 1ns/1ns
module crsa_source_model #(
  parameter int W = 24
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         advance,     // start of a new sample period
  input  wire logic         mute,        // host has cleared the source selectors
  input  wire logic [W-1:0] fresh,       // random word for the next period
  output logic      [W-1:0] sys_left,
  output logic      [W-1:0] sys_right,
  output logic      [W-1:0] async_left,
  output logic      [W-1:0] async_right
);
  // samples stand for a whole period, so the bench can compare at leisure
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sys_left    <= '0;
      sys_right   <= '0;
      async_left  <= '0;
      async_right <= '0;
    end else if (mute) begin
      // cleared selectors feed silence
      sys_left    <= '0;
      sys_right   <= '0;
      async_left  <= '0;
      async_right <= '0;
    end else if (advance) begin
      // both domains step together; four lanes differ so a swap shows
      sys_left    <= fresh;
      sys_right   <= ~fresh;
      async_left  <= fresh + W'(1);
      async_right <= ~fresh - W'(1);
    end
  end
endmodule : crsa_source_model

// >>> tb/crsa_core_test.sv
// testbench: rate fields, converter enables, lock and underclock behaviour
`timescale 1ns/1ns
module crsa_core_test;
  logic        clk, reset, ce, wr, rd;
  logic        rd_d;        // read taken on the last edge
  logic        advance, mute;
  logic [23:0] fresh;       // seeded random word handed to the sources
  logic [11:0] addr;
  logic [15:0] wdata, rdata;
  logic [23:0] sys_in_left, sys_in_right, async_in_left, async_in_right;
  logic [23:0] async_out_left, async_out_right, sys_out_left, sys_out_right;
  logic [3:0]  spdif_tx_rate_sel, effects_rate_sel, lock_event, lock_gpio;
  logic [3:0]  converter_system_rate_sel, converter_async_rate_sel;
  logic        underclock_event, underclock_gpio;
  logic [15:0] exp_q[$];    // expected read data, oldest first
  int          bad_count, n_checks;

  crsa_core crsa_core_i (
    .clk(clk), .reset(reset), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .sys_in_left(sys_in_left), .sys_in_right(sys_in_right),
    .async_in_left(async_in_left), .async_in_right(async_in_right),
    .async_out_left(async_out_left), .async_out_right(async_out_right),
    .sys_out_left(sys_out_left), .sys_out_right(sys_out_right),
    .spdif_tx_rate_sel(spdif_tx_rate_sel), .effects_rate_sel(effects_rate_sel),
    .converter_system_rate_sel(converter_system_rate_sel),
    .converter_async_rate_sel(converter_async_rate_sel), .lock_event(lock_event),
    .lock_gpio(lock_gpio), .underclock_event(underclock_event),
    .underclock_gpio(underclock_gpio));

  crsa_source_model crsa_source_model_i (
    .clk(clk), .reset(reset), .advance(advance), .mute(mute), .fresh(fresh),
    .sys_left(sys_in_left), .sys_right(sys_in_right),
    .async_left(async_in_left), .async_right(async_in_right));

  // 20 MHz clock
  always #25 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report

  // one-cycle write strobe
  task automatic bus_wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : bus_wr

  // one-cycle read strobe; the monitor checks the data a cycle later
  task automatic bus_rd(input logic [11:0] a, input logic [15:0] want);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    exp_q.push_back(want);
    @(posedge clk);
    rd <= 1'b0;
  endtask : bus_rd

  // let n edges pass, then step clear of the edge so outputs are settled
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  // every code 0..15 into the field(s); reserved codes must leave them alone
  task automatic sweep(input logic [11:0] a, input int hi, input int lo,
                       input logic [15:0] ok, input logic [3:0] init);
    logic [3:0]  cur;
    logic [15:0] w;
    cur = init;
    for (int c = 0; c < 16; c++) begin
      w = 16'(c) << hi;
      if (lo >= 0) w = w | (16'(c) << lo);
      if (ok[c]) cur = 4'(c);
      bus_wr(a, w);
      bus_rd(a, (16'(cur) << hi) | ((lo >= 0) ? (16'(cur) << lo) : 16'h0000));
    end
  endtask : sweep

  // pulse the sources into their next period
  task automatic step_sources();
    @(posedge clk);
    advance <= 1'b1;
    fresh   <= 24'($urandom);
    @(posedge clk);
    advance <= 1'b0;
  endtask : step_sources

  // read data stand for one cycle only, so look in that cycle, off the edge
  always @(posedge clk) rd_d <= rd;
  always @(negedge clk) begin
    if (rd_d && exp_q.size() > 0) check(32'(rdata), 32'(exp_q.pop_front()));
  end

  // hang guard, well beyond the expected few thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    final_report();
  end

  initial begin
    logic [11:0] ra [14];
    ra = '{12'h5c2, 12'h5e5, 12'h5e6, 12'h5e9, 12'h5ea, 12'h5eb, 12'he00,
           12'hee0, 12'hee1, 12'hee2, 12'hee3, 12'hee4, 12'hee5, 12'h123};
    clk = 1'b0; reset = 1'b1; ce = 1'b1; wr = 1'b0; rd = 1'b0; rd_d = 1'b0;
    addr = '0; wdata = '0; advance = 1'b0; mute = 1'b0;
    fresh = '0;
    bad_count = 0; n_checks = 0;
    void'($urandom(33));
    repeat (8) @(posedge clk);
    reset <= 1'b0;

    // reset values, including an unmapped address reading zero
    foreach (ra[i]) bus_rd(ra[i], ra[i] == 12'hee3 ? 16'h4000 :
                                  ra[i] == 12'hee5 ? 16'h0010 : 16'h0000);
    settle(2);
    check(32'(converter_async_rate_sel), 32'h8);
    $display("test reset done");

    // rate fields: valid codes land, reserved codes are refused
    sweep(12'h5c2, 4, -1, 16'h0007, 4'h0);
    sweep(12'h5e5, 11, 3, 16'h0307, 4'h0);
    sweep(12'h5e6, 11, 3, 16'h0307, 4'h0);
    sweep(12'h5e9, 11, 3, 16'h0307, 4'h0);
    sweep(12'h5ea, 11, 3, 16'h0307, 4'h0);
    sweep(12'h5eb, 11, 3, 16'h0307, 4'h0);
    sweep(12'he00, 11, -1, 16'h0307, 4'h0);
    sweep(12'hee2, 11, -1, 16'h0007, 4'h0);
    sweep(12'hee3, 11, -1, 16'h0300, 4'h8);
    settle(2);
    check(32'(spdif_tx_rate_sel), 32'h2);
    check(32'(effects_rate_sel), 32'h9);
    check(32'(converter_system_rate_sel), 32'h2);
    check(32'(converter_async_rate_sel), 32'h9);
    $display("test rate fields done");

    // all four paths on: lock is delayed, output silent until then
    step_sources();
    bus_wr(12'hee0, 16'h000f);
    bus_rd(12'hee1, 16'h000f);
    bus_rd(12'hee0, 16'h000f);
    settle(8);
    check(32'(lock_event), 32'h0);
    check(32'(async_out_left), 32'h0);
    settle(20);
    check(32'(lock_event), 32'hf);
    step_sources();
    settle(3);
    check(32'(async_out_left), 32'(sys_in_left));
    check(32'(async_out_right), 32'(sys_in_right));
    check(32'(sys_out_left), 32'(async_in_left));
    check(32'(sys_out_right), 32'(async_in_right));
    bus_wr(12'hee4, 16'h00f0);
    bus_rd(12'hee4, 16'h00ff);
    settle(2);
    check(32'(lock_gpio), 32'hf);
    $display("test enable and lock done");

    // rate change: clear sources, wait out the quiet time, then relock
    mute <= 1'b1;
    settle(2500);
    bus_wr(12'hee2, 16'h0800);
    @(posedge clk);
    mute <= 1'b0;
    step_sources();
    settle(2);
    check(32'(lock_event), 32'h0);
    check(32'(async_out_left), 32'h0);
    check(32'(converter_system_rate_sel), 32'h1);
    settle(25);
    check(32'(lock_event), 32'hf);
    check(32'(sys_out_right), 32'(async_in_right));
    $display("test rate change done");

    // starve the budget: second enable fails, the running path carries on
    bus_wr(12'hee0, 16'h0000);
    bus_wr(12'hee5, 16'h0004);
    bus_wr(12'hee0, 16'h0001);
    bus_wr(12'hee0, 16'h0003);
    settle(3);
    check(32'(underclock_event), 32'h1);
    check(32'(underclock_gpio), 32'h1);
    bus_rd(12'hee1, 16'h0011);
    bus_rd(12'hee1, 16'h0001);
    settle(25);
    check(32'(underclock_event), 32'h0);
    check(32'(lock_event), 32'h1);
    check(32'(async_out_right), 32'(sys_in_right));
    check(32'(async_out_left), 32'h0);
    $display("test underclock done");

    // clock enable low: a rate write in that window must be lost
    @(posedge clk);
    ce <= 1'b0;
    bus_wr(12'hee2, 16'h0000);
    @(posedge clk);
    ce <= 1'b1;
    bus_rd(12'hee2, 16'h0800);
    settle(2);
    check(32'(lock_event), 32'h1);
    $display("test clock enable done");

    settle(3);
    final_report();
  end
endmodule : crsa_core_test
